//--- hw/eeprom_host.sv
// Host controller that issues reads, byte loads and page writes to the parallel memory.
`timescale 1ns/100ps
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int unsigned WRITE_TIMEOUT = WRITE_CYC,     // Busy wait limit in cycles.
  parameter int unsigned LOAD_WINDOW   = LOAD_WINDOW_CYC // Page load window in cycles.
)
(
  input  wire logic              i_clk_sys,    // System clock, 10 MHz.
  input  wire logic              i_rst_b,      // Synchronous reset, active low.
  input  wire logic              i_ce,         // Clock enable, freezes state when low.
  input  wire host_cmd_t         i_cmd,        // Command word.
  input  wire logic              i_cmd_valid,  // Command offered.
  output logic                   o_cmd_ready,  // Pulses the cycle after a valid command was taken.
  output logic [DATA_W-1:0]      o_rd_data,    // Read data.
  output logic                   o_rd_valid,   // Read data pulse.
  output logic                   o_wr_done,    // Write cycle finished pulse.
  output logic                   o_wr_timeout, // Busy never released pulse.
  output logic                   o_busy,       // Device busy level.
  output mem_pins_t              o_pins,       // Memory control, address and data drive.
  input  wire logic [DATA_W-1:0] i_data_in,    // Memory data pins as read.
  input  wire logic              i_ready_n_in  // Ready/busy pin, low while busy.
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_WLOW, ST_WHIGH, ST_BUSY
  } state_t;

  state_t                state_reg;
  logic [TIMER_W-1:0]    tmr_reg;
  logic [TIMER_W-1:0]    win_reg;
  logic [PAGE_SEL_W-1:0] page_reg;
  logic                  in_page_reg;
  logic                  last_reg;
  logic [DATA_W-1:0]     sync1_reg;
  logic [DATA_W-1:0]     sync2_reg;
  logic [1:0]            rdy_sync_reg;

  // Page part of an address.
  function automatic logic [PAGE_SEL_W-1:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = a[ADDR_W-1:BYTE_SEL_W]; // [RULE2]
  endfunction : page_of

  // Two-flop synchronisers for pin inputs; only the second stage is read.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      rdy_sync_reg <= 2'h3;
    end
    else if (i_ce)
    begin
      sync1_reg    <= i_data_in;
      sync2_reg    <= sync1_reg;
      rdy_sync_reg <= {rdy_sync_reg[0], i_ready_n_in};
    end
  end

  wire logic dev_ready = rdy_sync_reg[1];
  // A page load may continue only to the same page and inside the window.
  wire logic same_page = in_page_reg && (page_of(i_cmd.addr) == page_reg)
                         && (win_reg < TIMER_W'(LOAD_WINDOW)); // [RULE10] [RULE8]

  // Main sequencer; pins change only from registers so glitches cannot reach the strobe.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      state_reg    <= ST_IDLE;
      tmr_reg      <= '0;
      o_cmd_ready  <= 1'b0;
      o_rd_valid   <= 1'b0;
      o_rd_data    <= '0;
      o_wr_done    <= 1'b0;
      o_wr_timeout <= 1'b0;
      last_reg     <= 1'b0;
      // Strobe and select idle high from reset onward. [RULE17]
      o_pins       <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1,
                        addr: '0, data_out: '0, data_oe: 1'b0};
    end
    else if (i_ce)
    begin
      o_cmd_ready  <= 1'b0;
      o_rd_valid   <= 1'b0;
      o_wr_done    <= 1'b0;
      o_wr_timeout <= 1'b0;
      tmr_reg      <= tmr_reg + 1'b1;
      case (state_reg)
        ST_IDLE:
        begin
          // Reads and new pages wait for ready; loads in an open page do not. [RULE19]
          if (i_cmd_valid && !o_cmd_ready && (dev_ready || (i_cmd.is_write && same_page)))
          begin
            o_cmd_ready       <= 1'b1;
            o_pins.addr       <= i_cmd.addr;
            o_pins.chip_sel_n <= 1'b0;
            tmr_reg           <= '0;
            if (i_cmd.is_write)
            begin
              // Enable high and data driven from the same edge at which the strobe falls. [RULE7] [RULE15]
              o_pins.out_en_n <= 1'b1;
              o_pins.write_n  <= 1'b0;
              o_pins.data_out <= i_cmd.data;
              o_pins.data_oe  <= 1'b1;
              last_reg        <= i_cmd.last;
              state_reg       <= ST_WLOW;
            end
            else
            begin
              o_pins.out_en_n <= 1'b0; // [RULE4]
              o_pins.data_oe  <= 1'b0;
              state_reg       <= ST_RD;
            end
          end
        end
        ST_RD:
        begin
          // Allow access time plus two synchroniser stages before sampling.
          if (tmr_reg >= TIMER_W'(READ_CYC + 2))
          begin
            o_rd_data         <= sync2_reg;
            o_rd_valid        <= 1'b1;
            o_pins.out_en_n   <= 1'b1;
            o_pins.chip_sel_n <= 1'b1;
            state_reg         <= ST_IDLE;
          end
        end
        ST_WLOW:
        begin
          // Strobe held well above the 20 ns noise filter. [RULE16]
          if (tmr_reg >= TIMER_W'(STROBE_LOW_CYC - 1))
          begin
            o_pins.write_n <= 1'b1;
            tmr_reg        <= '0;
            state_reg      <= ST_WHIGH;
          end
        end
        ST_WHIGH:
        begin
          if (tmr_reg >= TIMER_W'(STROBE_HIGH_CYC - 1))
          begin
            o_pins.data_oe    <= 1'b0;
            o_pins.chip_sel_n <= 1'b1;
            tmr_reg           <= '0;
            // Ending with select and strobe high closes the load phase. [RULE11]
            state_reg         <= last_reg ? ST_BUSY : ST_IDLE;
          end
        end
        ST_BUSY:
        begin
          // Wait for ready after the load window plus the write time. [RULE6] [RULE12]
          if (tmr_reg > TIMER_W'(8) && dev_ready)
          begin
            o_wr_done <= 1'b1;
            state_reg <= ST_IDLE;
          end
          else if (tmr_reg >= TIMER_W'(WRITE_TIMEOUT))
          begin
            o_wr_timeout <= 1'b1;
            state_reg    <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Page latch and load window timer, opened by the first load of a page. [RULE9]
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      page_reg    <= '0;
      in_page_reg <= 1'b0;
      win_reg     <= '0;
    end
    else if (i_ce)
    begin
      if (state_reg == ST_IDLE && i_cmd_valid && !o_cmd_ready && i_cmd.is_write
          && dev_ready && !same_page)
      begin
        page_reg    <= page_of(i_cmd.addr);
        in_page_reg <= !i_cmd.last;
        win_reg     <= '0;
      end
      else if (state_reg == ST_BUSY || win_reg >= TIMER_W'(LOAD_WINDOW))
      begin
        in_page_reg <= 1'b0;
      end
      else if (in_page_reg)
      begin
        win_reg <= win_reg + 1'b1;
      end
    end
  end

  // Busy indication for the user.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      o_busy <= 1'b0;
    else if (i_ce)
      o_busy <= (state_reg == ST_BUSY) || !dev_ready;
  end

  // Strobe is never low while output enable is low. [RULE15]
  strobe_safe_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE7]
    !o_pins.write_n |-> o_pins.out_en_n && !o_pins.chip_sel_n)
    else $error("Strobe low with enable low or select high.");
  // Strobe low lasts at least two cycles. [RULE16]
  strobe_width_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE16]
    $fell(o_pins.write_n) && i_ce |=> !o_pins.write_n)
    else $error("Strobe pulse too short.");
  // Data is driven throughout the strobe.
  data_drive_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE7]
    !o_pins.write_n |-> o_pins.data_oe)
    else $error("Strobe low without data driven.");
  // Host never drives data during a read.
  read_clash_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE4]
    !o_pins.out_en_n |-> !o_pins.data_oe)
    else $error("Bus contention during read.");
  // Select and strobe stay high while the device writes on its own, so no load can slip in.
  busy_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE19]
    state_reg == ST_BUSY |-> o_pins.chip_sel_n && o_pins.write_n)
    else $error("Select or strobe active during busy wait.");
  // Output enable is only pulled low inside a selected read with the strobe high.
  enable_select_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE4]
    !o_pins.out_en_n |-> !o_pins.chip_sel_n && o_pins.write_n)
    else $error("Output enable low outside a selected read.");
endmodule : eeprom_host

//--- hw/eeprom_host_pkg.sv
// Package of constants and carrier types for the parallel memory page-write host.
// Overview of operation
// [RULE1] Memory holds 256 pages of 32 bytes.
// [RULE2] Address bits 12..5 select the page.
// [RULE3] Address bits 4..0 select the byte.
// [RULE4] Device drives data only when selected and enabled.
// [RULE5] Ready/busy floats during reads.
// [RULE6] Internal write finishes alone within 10 ms.
// [RULE7] Byte load: strobe low, select low, enable high.
// [RULE8] Up to 32 loads within 300 us.
// [RULE9] Page bits latched at first strobe fall.
// [RULE10] Byte addresses in any order, same page.
// [RULE11] Host ends loading holding strobe high.
// [RULE12] Ready/busy low while internal write runs.
// [RULE13] Polling read returns inverted top data bit.
// [RULE14] Select high means standby, no writes.
// [RULE15] No write with enable low or strobe high.
// [RULE16] Strobe pulses under 20 ns ignored.
// [RULE17] Host keeps strobe high around power changes.
// [RULE18] After load window device writes regardless.
// [RULE19] Host waits for ready before next write.
package eeprom_host_pkg;
  localparam int unsigned PAGE_COUNT      = 256;
  localparam int unsigned PAGE_BYTES      = 32;
  localparam int unsigned ADDR_W          = 13;
  localparam int unsigned BYTE_SEL_W      = 5;
  localparam int unsigned PAGE_SEL_W      = 8;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned TOP_BIT         = 7;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  // Strobe pulse low and high times, least values in ns.
  localparam int unsigned STROBE_LOW_NS   = 200;
  localparam int unsigned STROBE_HIGH_NS  = 200;
  localparam int unsigned STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Output enable access time and settle for reads, in ns (longest, so wait rounds up).
  localparam int unsigned READ_ACCESS_NS  = 350;
  localparam int unsigned READ_CYC        = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Page load window and write cycle time.
  localparam int unsigned LOAD_WINDOW_US  = 300;
  localparam int unsigned LOAD_WINDOW_CYC = LOAD_WINDOW_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned LOAD_MAX_US     = 1000;
  localparam int unsigned LOAD_MAX_CYC    = LOAD_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned WRITE_MS        = 10;
  localparam int unsigned WRITE_CYC       = WRITE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W         = 20;

  // Pins toward the memory chip.
  typedef struct packed {
    logic              chip_sel_n;
    logic              out_en_n;
    logic              write_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic              data_oe;
  } mem_pins_t;

  // User command.
  typedef struct packed {
    logic              is_write;
    logic              last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } host_cmd_t;
endpackage : eeprom_host_pkg

//--- tb/mem_model.sv
// Behavioural model of the paged parallel memory as seen at the host pins.
`timescale 1ns/100ps
module mem_model
  import eeprom_host_pkg::*;
#(
  parameter int WIN = 20, // Load window in cycles, counted from the latest load.
  parameter int WR  = 60  // Internal write time in cycles when prompt.
)
(
  input  wire logic         i_clk,     // Clock that counts the window and write times and registers the data and busy outputs.
  input  wire logic         i_slow,    // Stretches the write past the host limit.
  input  wire mem_pins_t    i_pins,    // Pins driven by the host.
  output logic [DATA_W-1:0] o_data,    // Data pins as the host sees them.
  output logic              o_busy_oe, // High while ready/busy is pulled low.
  output int                o_faults   // Host protocol faults seen.
);
  logic [DATA_W-1:0]     mem [PAGE_COUNT*PAGE_BYTES];
  logic [DATA_W-1:0]     held [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] hit;
  logic [PAGE_SEL_W-1:0] page;
  logic [ADDR_W-1:0]     last_a;
  logic                  loading = 0, writing = 0, kick = 0;
  int                    cnt = 0;
  realtime               fell;

  // Erased contents at start, nothing pulled low.
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    o_faults = 0;
    o_data = 8'h00;
    o_busy_oe = 0;
  end

  // The first strobe fall of a cycle freezes the page bits.
  always @(negedge i_pins.write_n)
  begin
    fell = $realtime;
    if (writing) o_faults++;
    else if (!i_pins.chip_sel_n && i_pins.out_en_n && !loading)
    begin
      loading = 1;
      kick = 1; // Restarts the window count, which has run on while idle.
      hit = '0;
      page = i_pins.addr[ADDR_W-1:BYTE_SEL_W];
    end
  end

  // Data is taken at the strobe rise; glitches are dropped so noise cannot write.
  always @(posedge i_pins.write_n)
  begin
    if (loading && !i_pins.chip_sel_n && $realtime - fell >= 20)
    begin
      if (i_pins.addr[ADDR_W-1:BYTE_SEL_W] != page) o_faults++;
      held[i_pins.addr[BYTE_SEL_W-1:0]] = i_pins.data_out;
      hit[i_pins.addr[BYTE_SEL_W-1:0]] = 1'b1;
      last_a = i_pins.addr;
      kick = 1;
    end
  end

  // Load window, then the self-timed write; released data lines toggle every cycle.
  always @(posedge i_clk)
  begin
    cnt = kick ? 0 : cnt + 1;
    kick = 0;
    if (loading && cnt >= WIN)
    begin
      loading = 0;
      writing = 1;
      cnt = 0;
    end
    else if (writing && cnt >= (i_slow ? 4 * WR : WR))
    begin
      for (int i = 0; i < PAGE_BYTES; i++) if (hit[i]) mem[{page, 5'(i)}] = held[i];
      writing = 0;
    end
    o_busy_oe <= loading || writing;
    if (!i_pins.chip_sel_n && !i_pins.out_en_n)
      o_data <= (writing && i_pins.addr == last_a) ?
        {~held[last_a[4:0]][7], held[last_a[4:0]][6:0]} : mem[i_pins.addr];
    else
      o_data <= ~o_data;
  end
endmodule : mem_model

//--- tb/parallel_eeprom_page_write_tb.sv
// Self-checking bench: random page writes through the host, read back and compared.
`timescale 1ns/100ps
module parallel_eeprom_page_write_tb;
  import eeprom_host_pkg::*;
  logic              i_clk_sys = 0, i_rst_b = 0, i_cmd_valid = 0, slow = 0, ce = 1;
  logic              o_cmd_ready, o_rd_valid, o_wr_done, o_wr_timeout, o_busy, rdy_oe;
  host_cmd_t         i_cmd = '0;
  mem_pins_t         o_pins;
  logic [DATA_W-1:0] o_rd_data, i_data_in, shadow [PAGE_COUNT*PAGE_BYTES];
  int                mismatches = 0, n_compared = 0, seed = 14350, faults;

  // Clock at 10 MHz.
  always #50 i_clk_sys = ~i_clk_sys;

  // Short limits keep the run brief; the model's times are scaled to match.
  eeprom_host #(.WRITE_TIMEOUT(200), .LOAD_WINDOW(50)) i_dut (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(ce), .i_cmd(i_cmd),
    .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_wr_done(o_wr_done), .o_wr_timeout(o_wr_timeout),
    .o_busy(o_busy), .o_pins(o_pins), .i_data_in(i_data_in), .i_ready_n_in(!rdy_oe));
  mem_model i_mem (.i_clk(i_clk_sys), .i_slow(slow), .i_pins(o_pins), .o_data(i_data_in),
    .o_busy_oe(rdy_oe), .o_faults(faults));

  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("ERROR at %0t: %s", $time, what);
    end
  endtask : check

  // Offer a command at a falling edge and hold it until it is taken.
  task automatic send(input logic wr, last, input logic [12:0] a, input logic [7:0] d);
    int k;
    @(negedge i_clk_sys);
    i_cmd = '{wr, last, a, d};
    i_cmd_valid = 1;
    for (k = 0; k < 400 && o_cmd_ready !== 1'b1; k++) @(negedge i_clk_sys);
    check(k < 400, "command not taken");
    i_cmd_valid = 0;
  endtask : send

  task automatic rd(input logic [12:0] a);
    int k;
    send(1'b0, 1'b0, a, 8'h00);
    for (k = 0; k < 20 && o_rd_valid !== 1'b1; k++) @(negedge i_clk_sys);
    check(k < 20 && o_rd_data === shadow[a], "read data differs");
    check(o_busy === 1'b0, "busy shown during read");
  endtask : rd

  // Load n bytes of one page in scattered order, await the end, read back in reverse.
  task automatic page(input int n);
    logic [7:0]  p, d;
    logic [4:0]  b;
    logic [12:0] a [6];
    int          k;
    p = 8'($random(seed));
    b = 5'($random(seed));
    for (int i = 0; i < n; i++)
    begin
      a[i] = {p, b + 5'(i * 7)};
      d = 8'($random(seed));
      shadow[a[i]] = d;
      send(1'b1, i == n - 1, a[i], d);
    end
    for (k = 0; k < 600 && o_wr_done !== 1'b1 && o_wr_timeout !== 1'b1; k++)
      @(negedge i_clk_sys);
    check(k < 600 && o_wr_timeout === slow, "write end wrong");
    check(o_busy === 1'b1, "busy not shown at write end");
    for (int i = n - 1; i >= 0; i--) rd(a[i]);
  endtask : page

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Byte write, a six-byte page, random pages, then a write that outlasts the limit.
  initial
  begin
    repeat (4) @(negedge i_clk_sys);
    check(o_pins.write_n === 1'b1 && o_pins.chip_sel_n === 1'b1, "pins busy");
    i_rst_b = 1;
    page(1);
    page(6);
    // A frozen host must neither take an offered command nor select the memory.
    ce = 0;
    i_cmd = '{1'b0, 1'b0, 13'h0000, 8'h00};
    i_cmd_valid = 1;
    repeat (5)
    begin
      @(negedge i_clk_sys);
      check(o_cmd_ready === 1'b0 && o_pins.chip_sel_n === 1'b1, "frozen host moved");
    end
    i_cmd_valid = 0;
    ce = 1;
    repeat (20) page(1 + $unsigned($random(seed)) % 6);
    slow = 1;
    page(3);
    slow = 0;
    page(2);
    check(faults === 0, "model saw faults");
    end_of_test();
  end

  // Watchdog, far beyond the expected few thousand cycles.
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    mismatches++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : parallel_eeprom_page_write_tb
